// File: design/fcsc_pkg.sv
package fcsc_pkg;

   // Word-aligned register byte offsets on the Avalon-MM slave.
   localparam logic [4:0] OFS_CONFIG     = 5'h00;
   localparam logic [4:0] OFS_PROTECTION = 5'h04;
   localparam logic [4:0] OFS_STATUS     = 5'h08;
   localparam logic [4:0] OFS_COMMAND    = 5'h0C;
   localparam logic [4:0] OFS_DIVIDER    = 5'h10;
   localparam logic [4:0] OFS_SECURITY   = 5'h14;
   localparam logic [4:0] OFS_ARRAY_WR   = 5'h18;

   // Configuration field.
   localparam int         CFG_KEY_BIT    = 5;
   localparam logic [7:0] CFG_RW_MASK    = 8'hE0;
   localparam logic [7:0] CFG_RESET      = 8'h00;

   // Protection fields.
   localparam int         PROT_DIS_BIT   = 0;
   localparam int         PAGE_BITS      = 9;

   // Status bit positions.
   localparam int         ST_CBEF        = 7;
   localparam int         ST_CCF         = 6;
   localparam int         ST_PVIOL       = 5;
   localparam int         ST_ACCERR      = 4;
   localparam int         ST_BLANK       = 2;

   // Array write register: address in 15:0, data in 23:16.
   localparam int         AW_ADDR_LSB    = 0;
   localparam int         AW_DATA_LSB    = 16;

   // Backdoor key window.
   localparam logic [15:0] KEY_WIN_LO    = 16'hFFB0;
   localparam logic [15:0] KEY_WIN_HI    = 16'hFFB7;

   localparam logic [1:0] SEC_UNSECURED  = 2'h2;
   localparam logic [7:0] DIV_RESET      = 8'h00;

   typedef enum logic [7:0] {
      CMD_BLANK      = 8'h05,
      CMD_BYTE_PROG  = 8'h20,
      CMD_BURST_PROG = 8'h25,
      CMD_PAGE_ERASE = 8'h40,
      CMD_MASS_ERASE = 8'h41
   } fcsc_cmd_t;

   // Command-entry sequence states.
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_DATA = 3'b010,
      SEQ_CMD  = 3'b100
   } fcsc_seq_t;

   typedef struct packed {
      logic [7:0]  cmd;
      logic [15:0] addr;
      logic [7:0]  data;
   } fcsc_req_t;

   typedef struct packed {
      logic [2:0] index;
      logic [7:0] data;
   } fcsc_key_t;

endpackage : fcsc_pkg

// File: design/fcsc_flag.sv
`timescale 1ns/1ps
// Sticky flag: a set in the same cycle as a clear wins, so no event is lost.
module fcsc_flag
   import fcsc_pkg::*;
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic srst,
   // Control
   input  wire logic set_i,
   input  wire logic clr_i,
   // State
   output logic      flag_r
);

   always_ff @(posedge clk) begin
      if (srst) begin
         flag_r <= 1'b0;
      end else if (set_i) begin
         flag_r <= 1'b1;
      end else if (clr_i) begin
         flag_r <= 1'b0;
      end
   end

endmodule : fcsc_flag

// File: design/fcsc_ctrl.sv
`timescale 1ns/1ps
module fcsc_ctrl
   import fcsc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Avalon-MM slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Nonvolatile values sampled during reset
   input  wire logic [7:0]  nonvolatile_protection_byte,
   input  wire logic [1:0]  nonvolatile_security,
   // Background debug write port
   input  wire logic        debug_prot_we,
   input  wire logic [7:0]  debug_prot_data,
   // System events
   input  wire logic        stop_entry,
   input  wire logic        key_match_ok,
   // Array engine
   output logic             array_start,
   output fcsc_req_t        array_req,
   input  wire logic        array_done,
   input  wire logic        array_blank,
   // Backdoor key bytes
   output logic             key_valid,
   output fcsc_key_t        key_byte,
   // Security state
   output logic [1:0]       security_state_field
);

   logic [7:0]  flash_config_r;
   logic [7:0]  flash_protection_r;
   logic [7:0]  flash_command_r;
   logic [7:0]  flash_clock_divider_r;
   logic        div_loaded_r;
   logic [1:0]  sec_r;
   logic        ack_r;
   logic [31:0] rdata_r;
   logic        cbef_r;
   logic        ccf_r;
   logic        blank_r;
   logic        busy_r;
   logic        buf_full_r;
   fcsc_req_t   buf_r;
   fcsc_req_t   cur_r;
   fcsc_req_t   req_r;
   fcsc_seq_t   seq_r;
   logic        pviol_flag;
   logic        accerr_flag;
   logic        start_r;
   logic        kvalid_r;
   fcsc_key_t   key_r;

   logic        req;
   logic        wr_acc;
   logic [15:0] aw_addr;
   logic [7:0]  aw_data;
   logic        in_key_win;
   logic        wr_array;
   logic        wr_cmd;
   logic        wr_launch;
   logic        seq_err;
   logic        launch_ok;
   logic        legal_cmd;
   logic        is_pe;
   logic        prot_hit;
   logic        pviol_set;
   logic        accerr_set;
   logic        take_buf;

   // Bus handshake: one wait cycle, then the access completes.
   assign req         = read | write;
   assign waitrequest = req & ~ack_r;
   assign wr_acc      = write & ack_r & byteenable[0];
   assign readdata    = rdata_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Read data is captured in the wait cycle so it stands at the completing edge.
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_r <= 32'h0000_0000;
      end else if (read & ~ack_r) begin
         rdata_r <= 32'h0000_0000;
         unique case (address)
            OFS_CONFIG:     rdata_r[7:0] <= flash_config_r & CFG_RW_MASK;
            OFS_PROTECTION: rdata_r[7:0] <= flash_protection_r;
            OFS_STATUS:     rdata_r[7:0] <= {cbef_r, ccf_r, pviol_flag, accerr_flag,
                                             1'b0, blank_r, 2'b00};
            OFS_COMMAND:    rdata_r[7:0] <= flash_command_r;
            OFS_DIVIDER:    rdata_r[7:0] <= {div_loaded_r, flash_clock_divider_r[6:0]};
            OFS_SECURITY:   rdata_r[1:0] <= sec_r;
            default:        rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flash_config_r <= CFG_RESET;
      end else if (wr_acc && address == OFS_CONFIG) begin
         flash_config_r <= writedata[7:0] & CFG_RW_MASK;
      end
   end

   // The protection byte tracks the nonvolatile copy while reset is held.
   always_ff @(posedge clk) begin
      if (srst) begin
         flash_protection_r <= nonvolatile_protection_byte;
      end else if (debug_prot_we) begin
         flash_protection_r <= debug_prot_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flash_clock_divider_r <= DIV_RESET;
         div_loaded_r          <= 1'b0;
      end else if (wr_acc && address == OFS_DIVIDER) begin
         flash_clock_divider_r <= writedata[7:0];
         div_loaded_r          <= 1'b1;
      end
   end

   // Decode of the command-entry writes.
   assign aw_addr    = writedata[AW_ADDR_LSB +: 16];
   assign aw_data    = writedata[AW_DATA_LSB +: 8];
   assign in_key_win = aw_addr >= KEY_WIN_LO && aw_addr <= KEY_WIN_HI;
   assign wr_array   = wr_acc && address == OFS_ARRAY_WR &&
                       !(flash_config_r[CFG_KEY_BIT] && in_key_win);
   assign wr_cmd     = wr_acc && address == OFS_COMMAND;
   assign wr_launch  = wr_acc && address == OFS_STATUS && writedata[ST_CBEF];

   assign legal_cmd = req_r.cmd inside {CMD_BLANK, CMD_BYTE_PROG, CMD_BURST_PROG,
                                        CMD_PAGE_ERASE, CMD_MASS_ERASE};
   assign is_pe     = req_r.cmd != CMD_BLANK;

   // Above the boundary page program and erase are locked; mass erase touches it always.
   assign prot_hit  = !flash_protection_r[PROT_DIS_BIT] && is_pe &&
                      (req_r.cmd == CMD_MASS_ERASE ||
                       req_r.addr[15:PAGE_BITS] > flash_protection_r[7:1]);

   // A write out of order, or any entry while the buffer is full, breaks the sequence.
   always_comb begin
      seq_err = 1'b0;
      if (wr_array || wr_cmd || wr_launch) begin
         if (!cbef_r) begin
            seq_err = 1'b1;
         end else begin
            unique case (seq_r)
               SEQ_IDLE: seq_err = !wr_array;
               SEQ_DATA: seq_err = !wr_cmd;
               SEQ_CMD:  seq_err = !wr_launch;
            endcase
         end
      end
   end

   // A queued command while one runs is allowed only for burst programming.
   assign launch_ok  = wr_launch && !seq_err && seq_r == SEQ_CMD && legal_cmd &&
                       !(is_pe && !div_loaded_r) && !prot_hit &&
                       (!busy_r || (req_r.cmd == CMD_BURST_PROG &&
                                    cur_r.cmd == CMD_BURST_PROG));
   assign pviol_set  = wr_launch && !seq_err && seq_r == SEQ_CMD && legal_cmd &&
                       prot_hit;
   assign accerr_set = seq_err ||
                       (wr_launch && seq_r == SEQ_CMD && !legal_cmd) ||
                       (wr_launch && seq_r == SEQ_CMD && legal_cmd && is_pe &&
                        !div_loaded_r) ||
                       (wr_launch && seq_r == SEQ_CMD && legal_cmd && busy_r &&
                        !(req_r.cmd == CMD_BURST_PROG && cur_r.cmd == CMD_BURST_PROG)) ||
                       (stop_entry && busy_r);

   always_ff @(posedge clk) begin
      if (srst) begin
         seq_r <= SEQ_IDLE;
         req_r <= '0;
      end else if (seq_err || wr_launch) begin
         seq_r <= SEQ_IDLE;
      end else if (wr_array) begin
         seq_r      <= SEQ_DATA;
         req_r.addr <= aw_addr;
         req_r.data <= aw_data;
      end else if (wr_cmd) begin
         seq_r     <= SEQ_CMD;
         req_r.cmd <= writedata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         flash_command_r <= 8'h00;
      end else if (wr_cmd && !seq_err) begin
         flash_command_r <= writedata[7:0];
      end
   end

   fcsc_flag u_pviol (
      .clk    (clk),
      .srst   (srst),
      .set_i  (pviol_set),
      .clr_i  (wr_acc && address == OFS_STATUS && writedata[ST_PVIOL]),
      .flag_r (pviol_flag)
   );

   fcsc_flag u_accerr (
      .clk    (clk),
      .srst   (srst),
      .set_i  (accerr_set),
      .clr_i  (wr_acc && address == OFS_STATUS && writedata[ST_ACCERR]),
      .flag_r (accerr_flag)
   );

   // The engine pulls the buffered command as soon as it is free.
   assign take_buf = buf_full_r && (!busy_r || array_done);

   always_ff @(posedge clk) begin
      if (srst) begin
         buf_full_r <= 1'b0;
         buf_r      <= '0;
      end else if (launch_ok) begin
         buf_full_r <= 1'b1;
         buf_r      <= req_r;
      end else if (take_buf) begin
         buf_full_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         busy_r  <= 1'b0;
         cur_r   <= '0;
         start_r <= 1'b0;
      end else begin
         start_r <= take_buf;
         if (take_buf) begin
            busy_r <= 1'b1;
            cur_r  <= buf_r;
         end else if (array_done || stop_entry) begin
            busy_r <= 1'b0;
         end
      end
   end

   // The buffer reopens for a follow-on burst once the burst reaches the array.
   always_ff @(posedge clk) begin
      if (srst) begin
         cbef_r <= 1'b1;
      end else if (launch_ok) begin
         cbef_r <= 1'b0;
      end else if (take_buf && buf_r.cmd == CMD_BURST_PROG) begin
         cbef_r <= 1'b1;
      end else if (!buf_full_r && !busy_r) begin
         cbef_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ccf_r <= 1'b1;
      end else begin
         ccf_r <= !launch_ok && !buf_full_r && !(busy_r && !array_done);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         blank_r <= 1'b0;
      end else if (launch_ok) begin
         blank_r <= 1'b0;
      end else if (busy_r && array_done && cur_r.cmd == CMD_BLANK) begin
         blank_r <= array_blank;
      end
   end

   // Security code follows the nonvolatile copy while reset is held.
   always_ff @(posedge clk) begin
      if (srst) begin
         sec_r <= nonvolatile_security;
      end else if (key_match_ok ||
                   (busy_r && array_done && cur_r.cmd == CMD_BLANK && array_blank)) begin
         sec_r <= SEC_UNSECURED;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         kvalid_r <= 1'b0;
         key_r    <= '0;
      end else begin
         kvalid_r <= wr_acc && address == OFS_ARRAY_WR &&
                     flash_config_r[CFG_KEY_BIT] && in_key_win;
         if (wr_acc && address == OFS_ARRAY_WR) begin
            key_r.index <= aw_addr[2:0];
            key_r.data  <= aw_data;
         end
      end
   end

   assign array_start          = start_r;
   assign array_req            = cur_r;
   assign key_valid            = kvalid_r;
   assign key_byte             = key_r;
   assign security_state_field = sec_r;

   sequence s_launch_prot;
      launch_ok ##1 !cbef_r;
   endsequence

   a_cfg_low_zero: assert property (@(posedge clk) disable iff (srst)
      flash_config_r[4:0] == 5'h00)
      else $error("config low bits not zero");
   a_key_no_start: assert property (@(posedge clk) disable iff (srst)
      (wr_acc && address == OFS_ARRAY_WR && flash_config_r[CFG_KEY_BIT] && in_key_win)
      |=> key_valid && $stable(seq_r))
      else $error("key write not routed to key port");
   a_prot_user_ro: assert property (@(posedge clk) disable iff (srst)
      !debug_prot_we |=> $stable(flash_protection_r))
      else $error("protection changed without debug write");
   a_launch_clears: assert property (@(posedge clk) disable iff (srst)
      launch_ok |-> s_launch_prot)
      else $error("buffer-empty not cleared on launch");
   a_ccf_busy_low: assert property (@(posedge clk) disable iff (srst)
      (busy_r && !array_done) |=> !ccf_r)
      else $error("complete flag set while busy");
   a_pviol_ignore: assert property (@(posedge clk) disable iff (srst)
      pviol_set |-> !launch_ok ##1 pviol_flag)
      else $error("violation not flagged or command run");
   a_illegal_err: assert property (@(posedge clk) disable iff (srst)
      (wr_launch && seq_r == SEQ_CMD && !legal_cmd) |=> accerr_flag && !buf_full_r)
      else $error("illegal code not flagged");
   a_div_gate: assert property (@(posedge clk) disable iff (srst)
      launch_ok && is_pe |-> div_loaded_r)
      else $error("program or erase launched before divider write");
   a_unsecure: assert property (@(posedge clk) disable iff (srst)
      key_match_ok |=> security_state_field == SEC_UNSECURED)
      else $error("key match did not unsecure");
   a_status_zero: assert property (@(posedge clk) disable iff (srst)
      (read && !ack_r && address == OFS_STATUS) |=> readdata[3] == 1'b0 &&
      readdata[1:0] == 2'b00)
      else $error("status reserved bits not zero");

endmodule : fcsc_ctrl

// File: test/test_flash_command_status_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_flash_command_status_control;
   import fcsc_pkg::*;
   logic        clk, srst, read, write, debug_prot_we, stop_entry, key_match_ok;
   logic        array_done, array_blank, array_start, waitrequest, key_valid;
   logic [4:0]  address;
   logic [31:0] writedata, readdata, rdw;
   logic [7:0]  debug_prot_data;
   logic [1:0]  security_state_field;
   logic [7:0]  nv_prot;
   logic [1:0]  nv_sec;
   logic [3:0]  be;
   fcsc_req_t   array_req, last_req;
   fcsc_key_t   key_byte, last_key;
   int          n_mismatch, checks, n_start, n_key, s, k;
   logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};

   fcsc_ctrl dut_u (
      .clk(clk), .srst(srst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(be), .readdata(readdata),
      .waitrequest(waitrequest), .nonvolatile_protection_byte(nv_prot),
      .nonvolatile_security(nv_sec), .debug_prot_we(debug_prot_we),
      .debug_prot_data(debug_prot_data), .stop_entry(stop_entry),
      .key_match_ok(key_match_ok), .array_start(array_start), .array_req(array_req),
      .array_done(array_done), .array_blank(array_blank), .key_valid(key_valid),
      .key_byte(key_byte), .security_state_field(security_state_field));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Pulses are counted here so that no scenario can miss a one-cycle output.
   always @(posedge clk) begin
      if (array_start === 1'b1) begin
         n_start++;
         last_req = array_req;
      end
      if (key_valid === 1'b1) begin
         n_key++;
         last_key = key_byte;
      end
   end

   task close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      n = 0;
      // Waitrequest is sampled at the rising edge, so the access ends on that edge.
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin
         n_mismatch++;
         close_out();
      end else begin
         rdw = readdata;
         write <= 1'b0;
         read  <= 1'b0;
      end
   endtask : bus

   task wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   // Bits outside the mask must match too when they lie above bit 7.
   task rdchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rdw & {24'hFFFFFF, m}, {24'h0, e})
   endtask : rdchk

   task pulse(input int sel, input logic [7:0] v);
      @(posedge clk);
      case (sel)
         0: begin
            array_done  <= 1'b1;
            array_blank <= v[0];
         end
         1: begin
            debug_prot_we   <= 1'b1;
            debug_prot_data <= v;
         end
         2: stop_entry <= 1'b1;
         default: key_match_ok <= 1'b1;
      endcase
      @(posedge clk);
      array_done    <= 1'b0;
      debug_prot_we <= 1'b0;
      stop_entry    <= 1'b0;
      key_match_ok  <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : pulse

   task do_cmd(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
      wr(OFS_ARRAY_WR, {8'h00, d, a});
      wr(OFS_COMMAND, {24'h0, c});
      wr(OFS_STATUS, 32'h80);
   endtask : do_cmd

   task wait_start(input int e);
      for (int i = 0; i < 20 && n_start != e; i++) @(posedge clk);
   endtask : wait_start

   task do_reset;
      @(posedge clk);
      srst <= 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
   endtask : do_reset

   task s_reset;
      rdchk(OFS_CONFIG, 8'hFF, 8'h00);
      rdchk(OFS_PROTECTION, 8'hFF, 8'h81);
      rdchk(OFS_STATUS, 8'hFF, 8'hC0);
      rdchk(OFS_SECURITY, 8'h03, 8'h00);
      rdchk(5'h1C, 8'hFF, 8'h00);
   endtask : s_reset

   task s_regs;
      wr(OFS_CONFIG, 32'hFF);
      rdchk(OFS_CONFIG, 8'hFF, 8'hE0);
      wr(OFS_CONFIG, 32'h00);
      rdchk(OFS_CONFIG, 8'hFF, 8'h00);
      be <= 4'h0;
      wr(OFS_CONFIG, 32'hFF);
      be <= 4'hF;
      rdchk(OFS_CONFIG, 8'hFF, 8'h00);
      wr(OFS_PROTECTION, 32'h00);
      rdchk(OFS_PROTECTION, 8'hFF, 8'h81);
      pulse(1, 8'h80);
      rdchk(OFS_PROTECTION, 8'hFF, 8'h80);
      pulse(1, 8'h81);
      wr(OFS_STATUS, 32'h4F);
      rdchk(OFS_STATUS, 8'hFF, 8'hC0);
   endtask : s_regs

   task s_refuse;
      s = n_start;
      do_cmd(8'h20, 16'h1000, 8'h3C);
      wait_start(s + 1);
      `CHK(n_start, s)
      rdchk(OFS_STATUS, 8'h10, 8'h10);
      wr(OFS_STATUS, 32'h00);
      rdchk(OFS_STATUS, 8'h10, 8'h10);
      wr(OFS_STATUS, 32'h10);
      rdchk(OFS_STATUS, 8'h10, 8'h00);
      wr(OFS_DIVIDER, 32'h13);
      rdchk(OFS_DIVIDER, 8'h80, 8'h80);
      wr(OFS_COMMAND, 32'h20);
      wr(OFS_STATUS, 32'h80);
      rdchk(OFS_STATUS, 8'h10, 8'h10);
      wr(OFS_STATUS, 32'h10);
      do_cmd(8'h33, 16'h1000, 8'h00);
      rdchk(OFS_STATUS, 8'h10, 8'h10);
      wr(OFS_STATUS, 32'h10);
      `CHK(n_start, s)
   endtask : s_refuse

   task s_codes;
      for (int i = 0; i < 5; i++) begin
         s = n_start;
         do_cmd(codes[i], 16'(16'h0200 + i), 8'(8'hA0 + i));
         wait_start(s + 1);
         `CHK(n_start, s + 1)
         `CHK(last_req.cmd, codes[i])
         `CHK(last_req.addr, 16'(16'h0200 + i))
         `CHK(last_req.data, 8'(8'hA0 + i))
         rdchk(OFS_STATUS, 8'h40, 8'h00);
         pulse(0, {7'h0, i == 0});
         rdchk(OFS_STATUS, 8'hFF, (i == 0) ? 8'hC4 : 8'hC0);
         if (i == 0) begin
            rdchk(OFS_SECURITY, 8'h03, 8'h02);
         end
      end
   endtask : s_codes

   // The region above boundary 0x40 is protected: 0x81FF is the last free byte.
   task s_prot;
      pulse(1, 8'h80);
      s = n_start;
      do_cmd(8'h40, 16'h8200, 8'h00);
      wait_start(s + 1);
      `CHK(n_start, s)
      rdchk(OFS_STATUS, 8'h30, 8'h20);
      wr(OFS_STATUS, 32'h20);
      rdchk(OFS_STATUS, 8'h20, 8'h00);
      do_cmd(8'h20, 16'h81FF, 8'h11);
      wait_start(s + 1);
      `CHK(n_start, s + 1)
      pulse(0, 8'h00);
      pulse(1, 8'h81);
   endtask : s_prot

   task s_busy;
      s = n_start;
      do_cmd(8'h25, 16'h0300, 8'h55);
      wait_start(s + 1);
      do_cmd(8'h25, 16'h0301, 8'h77);
      rdchk(OFS_STATUS, 8'hD0, 8'h00);
      pulse(0, 8'h00);
      wait_start(s + 2);
      `CHK(n_start, s + 2)
      `CHK(last_req.addr, 16'h0301)
      rdchk(OFS_STATUS, 8'h80, 8'h80);
      do_cmd(8'h20, 16'h0302, 8'h66);
      rdchk(OFS_STATUS, 8'h10, 8'h10);
      wr(OFS_STATUS, 32'h10);
      pulse(2, 8'h00);
      rdchk(OFS_STATUS, 8'h10, 8'h10);
      `CHK(n_start, s + 2)
   endtask : s_busy

   task s_key;
      k = n_key;
      rdchk(OFS_PROTECTION, 8'hFF, 8'hA1);
      wr(OFS_DIVIDER, 32'h13);
      wr(OFS_CONFIG, 32'h20);
      wr(OFS_ARRAY_WR, {8'h00, 8'h5A, 16'hFFB3});
      repeat (2) @(posedge clk);
      `CHK(n_key, k + 1)
      `CHK(last_key.index, 3'h3)
      `CHK(last_key.data, 8'h5A)
      wr(OFS_CONFIG, 32'h00);
      s = n_start;
      do_cmd(8'h20, 16'hFFB4, 8'h77);
      wait_start(s + 1);
      `CHK(n_start, s + 1)
      `CHK(n_key, k + 1)
      pulse(0, 8'h00);
      `CHK(security_state_field, 2'h1)
      pulse(3, 8'h00);
      `CHK(security_state_field, 2'h2)
   endtask : s_key

   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      close_out();
   end

   initial begin
      srst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0;
      debug_prot_we = 1'b0;
      debug_prot_data = 8'h00;
      stop_entry = 1'b0;
      key_match_ok = 1'b0;
      array_done = 1'b0;
      array_blank = 1'b0;
      nv_prot = 8'h81;
      nv_sec = 2'h0;
      be = 4'hF;
      do_reset();
      s_reset();
      s_regs();
      s_refuse();
      s_codes();
      s_prot();
      s_busy();
      // New nonvolatile values must be picked up by the next reset.
      nv_prot <= 8'hA1;
      nv_sec  <= 2'h1;
      do_reset();
      s_key();
      close_out();
   end
endmodule : test_flash_command_status_control
